// >>> verilog/host_port_pkg.sv
// Purpose: constants for the host status and interrupt port
// Assumes: 8-bit host bus, 40 MHz system clock
// Notes:   status latch and response byte bit positions, command codes
package host_port_pkg;
    localparam int STAT_DIR_BIT    = 7;
    localparam int STAT_BUSY_BIT   = 6;
    localparam int STAT_CMD_BIT    = 5;
    localparam int STAT_MSG_BIT    = 4;
    localparam int STAT_REQ_BIT    = 3;
    localparam int STAT_INVREQ_BIT = 2;
    localparam int STAT_PARERR_BIT = 1;
    localparam int STAT_SELFT_BIT  = 0;
    localparam int RESP_ERR_BIT    = 6;

    localparam logic [3:0] CMD_SW_RESET    = 4'h0;
    localparam logic [3:0] CMD_STATUS_READ = 4'h1;
    localparam logic [3:0] CMD_WRITE_DATA  = 4'h2;
    localparam logic [3:0] CMD_ID_READ     = 4'h3;
    localparam logic [3:0] CMD_SELECT      = 4'h4;
    localparam logic [3:0] CMD_INT_DISABLE = 4'h5;
    localparam logic [3:0] CMD_INT_ENABLE  = 4'h6;
    localparam logic [3:0] CMD_READ_DATA   = 4'h7;

    localparam logic [7:0] ID_BYTE_VALUE   = 8'h08;
    localparam logic       MASK_RESET      = 1'b1;
    localparam logic       SELFT_RESET     = 1'b1;
endpackage

// >>> verilog/host_status_interrupt_port.sv
// Purpose: status latch, interrupt request and response byte of the host port
// Assumes: host bus pins arrive asynchronously; controller core on clk_sys_i
// Notes:   strobe and ack pass a three-flop synchroniser, other pins two flops, strobe counted when stages 2 and 3 agree
`timescale 1ns/1ps

module host_status_interrupt_port
    import host_port_pkg::*;
(
    input  wire logic       clk_sys_i,
    input  wire logic       sys_rst_i,
    input  wire logic [3:0] dev_addr_i,
    input  wire logic [7:0] cmd_addr_i,
    input  wire logic       cmd_strobe_i,
    input  wire logic       cmd_parity_i,
    input  wire logic       int_ack_i,
    input  wire logic [7:0] data_i,
    output logic      [7:0] data_o,
    output logic            data_oe_o,
    output logic            int_req_o,
    input  wire logic       core_req_i,
    input  wire logic       core_dir_i,
    input  wire logic       core_cmd_i,
    input  wire logic       core_msg_i,
    input  wire logic       core_int_i,
    input  wire logic       core_done_i,
    input  wire logic       selftest_done_i,
    input  wire logic       selftest_pass_i,
    input  wire logic [7:0] core_rd_data_i,
    output logic      [7:0] wr_data_o,
    output logic            wr_strobe_o,
    output logic            rd_strobe_o,
    output logic            sw_reset_o,
    output logic            select_o,
    output logic      [7:0] status_latch_read_o
);
    typedef enum logic [2:0] {
        IRQ_IDLE = 3'b001,
        IRQ_REQ  = 3'b010,
        IRQ_RESP = 3'b100
    } irq_state_e;

    function automatic logic agree(input logic [2:0] s);
        agree = s[1] & s[2];
    endfunction

    logic [2:0] strb_sync_q, strb_sync_d;
    logic [2:0] ack_sync_q,  ack_sync_d;
    logic [7:0] ca_s1_q, ca_s2_q, ca_s1_d, ca_s2_d;
    logic       par_s1_q, par_s2_q, par_s1_d, par_s2_d;
    logic [7:0] dat_s1_q, dat_s2_q, dat_s1_d, dat_s2_d;
    logic       strb_lvl_q, strb_lvl_d;
    logic       ack_lvl_q,  ack_lvl_d;

    logic       busy_q, busy_d;
    logic       invreq_q, invreq_d;
    logic       parerr_q, parerr_d;
    logic       selft_q, selft_d;
    logic       mask_q, mask_d;
    logic       errint_q, errint_d;
    logic       pend_q, pend_d;
    logic       msg_seen_q, msg_seen_d;
    irq_state_e irq_q, irq_d;
    logic [7:0] data_q, data_d;
    logic       oe_q, oe_d;
    logic [7:0] wr_data_q, wr_data_d;
    logic       wr_stb_q, wr_stb_d, rd_stb_q, rd_stb_d;
    logic       swr_q, swr_d, sel_q, sel_d;

    logic       strb_rise, ack_fall, par_bad, addressed;
    logic [3:0] cmd;
    logic [7:0] status_w;
    logic       req_v;

    // synchronisers: stage 1 feeds stage 2 only
    always_comb begin
        strb_sync_d = {strb_sync_q[1:0], cmd_strobe_i};
        ack_sync_d  = {ack_sync_q[1:0], int_ack_i};
        ca_s1_d     = cmd_addr_i;
        ca_s2_d     = ca_s1_q;
        par_s1_d    = cmd_parity_i;
        par_s2_d    = par_s1_q;
        dat_s1_d    = data_i;
        dat_s2_d    = dat_s1_q;
        strb_lvl_d  = strb_lvl_q;
        ack_lvl_d   = ack_lvl_q;
        if (strb_sync_q[1] == strb_sync_q[2]) begin
            strb_lvl_d = agree(strb_sync_q);
        end
        if (ack_sync_q[1] == ack_sync_q[2]) begin
            ack_lvl_d = agree(ack_sync_q);
        end
    end

    assign strb_rise = strb_lvl_d & ~strb_lvl_q;
    assign ack_fall  = ~ack_lvl_d & ack_lvl_q;
    assign cmd       = ca_s2_q[7:4];
    assign addressed = (ca_s2_q[3:0] == dev_addr_i);
    assign par_bad   = ~(^{ca_s2_q, par_s2_q});                   // odd parity expected
    assign req_v     = core_req_i;

    always_comb begin
        status_w = 8'h00;
        status_w[STAT_DIR_BIT]    = req_v & core_dir_i;
        status_w[STAT_BUSY_BIT]   = busy_q;
        status_w[STAT_CMD_BIT]    = req_v & core_cmd_i;
        status_w[STAT_MSG_BIT]    = req_v & core_msg_i;
        status_w[STAT_REQ_BIT]    = req_v;
        status_w[STAT_INVREQ_BIT] = invreq_q;
        status_w[STAT_PARERR_BIT] = parerr_q;
        status_w[STAT_SELFT_BIT]  = selft_q;
    end

    always_comb begin
        busy_d     = busy_q;
        invreq_d   = invreq_q;
        parerr_d   = parerr_q;
        selft_d    = selft_q;
        mask_d     = mask_q;
        errint_d   = errint_q & !((irq_q == IRQ_RESP) && ack_fall);
        pend_d     = pend_q & (irq_q != IRQ_IDLE);
        msg_seen_d = msg_seen_q;
        irq_d      = irq_q;
        data_d     = data_q;
        oe_d       = oe_q;
        wr_data_d  = wr_data_q;
        wr_stb_d   = 1'b0;
        rd_stb_d   = 1'b0;
        swr_d      = 1'b0;
        sel_d      = 1'b0;
        if (selftest_done_i && selftest_pass_i) begin
            selft_d = 1'b0;
        end
        if (core_int_i && (!mask_q) && (!busy_q || core_req_i)) begin
            pend_d = 1'b1;
        end
        if (core_done_i) begin
            busy_d = 1'b1;
        end
        if (oe_q && !strb_lvl_q && irq_q != IRQ_RESP) begin
            oe_d = 1'b0;
        end
        if (strb_rise) begin
            if (par_bad) begin
                parerr_d = 1'b1;
                errint_d = 1'b1;
                pend_d   = 1'b1;
            end else if (addressed) begin
                case (cmd)
                    CMD_SW_RESET: begin
                        swr_d    = 1'b1;
                        busy_d   = 1'b0;
                        mask_d   = MASK_RESET;
                        invreq_d = 1'b0;
                        parerr_d = 1'b0;
                        errint_d = 1'b0;
                        pend_d   = 1'b0;
                    end
                    CMD_STATUS_READ: begin
                        data_d = status_w;
                        oe_d   = 1'b1;
                    end
                    CMD_ID_READ: begin
                        data_d = ID_BYTE_VALUE;
                        oe_d   = 1'b1;
                    end
                    CMD_SELECT: begin
                        sel_d  = 1'b1;
                        busy_d = 1'b1;
                    end
                    CMD_INT_DISABLE: mask_d = 1'b1;
                    CMD_INT_ENABLE:  mask_d = 1'b0;
                    CMD_WRITE_DATA, CMD_READ_DATA: begin
                        if (!req_v) begin
                            invreq_d = 1'b1;
                            errint_d = 1'b1;
                            pend_d   = 1'b1;
                        end else if (cmd == CMD_WRITE_DATA) begin
                            wr_data_d = dat_s2_q;
                            wr_stb_d  = 1'b1;
                        end else begin
                            data_d   = core_rd_data_i;
                            oe_d     = 1'b1;
                            rd_stb_d = 1'b1;
                            msg_seen_d = core_msg_i & core_dir_i & core_cmd_i;
                        end
                    end
                    default: ;
                endcase
            end
        end
        if (msg_seen_q && !req_v) begin
            busy_d     = 1'b0;
            invreq_d   = 1'b0;
            msg_seen_d = 1'b0;
        end
        case (irq_q)
            IRQ_IDLE: if (pend_q) begin
                irq_d  = IRQ_REQ;
            end
            IRQ_REQ: if (ack_lvl_q) begin
                irq_d  = IRQ_RESP;
                data_d = {status_w[STAT_DIR_BIT], errint_q, status_w[STAT_CMD_BIT],
                          status_w[STAT_MSG_BIT], dev_addr_i};
                oe_d   = 1'b1;
            end
            IRQ_RESP: if (ack_fall) begin
                irq_d    = IRQ_IDLE;
                oe_d     = 1'b0;
            end
            default: irq_d = IRQ_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            strb_sync_q <= 3'h0;
            ack_sync_q  <= 3'h0;
            ca_s1_q     <= 8'h00;
            ca_s2_q     <= 8'h00;
            par_s1_q    <= 1'b0;
            par_s2_q    <= 1'b0;
            dat_s1_q    <= 8'h00;
            dat_s2_q    <= 8'h00;
            strb_lvl_q  <= 1'b0;
            ack_lvl_q   <= 1'b0;
            busy_q      <= 1'b0;
            invreq_q    <= 1'b0;
            parerr_q    <= 1'b0;
            selft_q     <= SELFT_RESET;
            mask_q      <= MASK_RESET;
            errint_q    <= 1'b0;
            pend_q      <= 1'b0;
            msg_seen_q  <= 1'b0;
            irq_q       <= IRQ_IDLE;
            data_q      <= 8'h00;
            oe_q        <= 1'b0;
            wr_data_q   <= 8'h00;
            wr_stb_q    <= 1'b0;
            rd_stb_q    <= 1'b0;
            swr_q       <= 1'b0;
            sel_q       <= 1'b0;
        end else begin
            strb_sync_q <= strb_sync_d;
            ack_sync_q  <= ack_sync_d;
            ca_s1_q     <= ca_s1_d;
            ca_s2_q     <= ca_s2_d;
            par_s1_q    <= par_s1_d;
            par_s2_q    <= par_s2_d;
            dat_s1_q    <= dat_s1_d;
            dat_s2_q    <= dat_s2_d;
            strb_lvl_q  <= strb_lvl_d;
            ack_lvl_q   <= ack_lvl_d;
            busy_q      <= busy_d;
            invreq_q    <= invreq_d;
            parerr_q    <= parerr_d;
            selft_q     <= selft_d;
            mask_q      <= mask_d;
            errint_q    <= errint_d;
            pend_q      <= pend_d;
            msg_seen_q  <= msg_seen_d;
            irq_q       <= irq_d;
            data_q      <= data_d;
            oe_q        <= oe_d;
            wr_data_q   <= wr_data_d;
            wr_stb_q    <= wr_stb_d;
            rd_stb_q    <= rd_stb_d;
            swr_q       <= swr_d;
            sel_q       <= sel_d;
        end
    end

    assign data_o              = data_q;
    assign data_oe_o           = oe_q;
    assign int_req_o           = (irq_q == IRQ_REQ) || (irq_q == IRQ_RESP);
    assign wr_data_o           = wr_data_q;
    assign wr_strobe_o         = wr_stb_q;
    assign rd_strobe_o         = rd_stb_q;
    assign sw_reset_o          = swr_q;
    assign select_o            = sel_q;
    assign status_latch_read_o = status_w;
endmodule

// >>> verif/host_model.sv
// Purpose: host processor model for the host port
// Assumes: port inputs change at the falling clock edge
// Notes:   released address and data lines show the inverse of their last value, parity line holds
`timescale 1ns/1ps
module host_model (
    input  wire logic       clk_sys_i,
    input  wire logic [7:0] bus_data_i,
    input  wire logic       bus_oe_i,
    output logic      [7:0] cmd_addr_o,
    output logic            cmd_strobe_o,
    output logic            cmd_parity_o,
    output logic            int_ack_o,
    output logic      [7:0] bus_data_o
);
    initial begin
        cmd_addr_o   = 8'h00;
        cmd_strobe_o = 1'b0;
        cmd_parity_o = 1'b1;
        int_ack_o    = 1'b0;
        bus_data_o   = 8'h00;
    end
    // one command cycle; rd holds {oe, data} seen before the strobe drops
    task automatic command(input logic [3:0] cmd, input logic [3:0] adr, input logic bad,
                           input logic [7:0] wdat, output logic [8:0] rd);
        @(negedge clk_sys_i);
        cmd_addr_o   = {cmd, adr};
        cmd_parity_o = ~(^{cmd, adr}) ^ bad;
        bus_data_o   = wdat;
        repeat (3) @(negedge clk_sys_i);
        cmd_strobe_o = 1'b1;
        repeat (8) @(negedge clk_sys_i);
        rd = {bus_oe_i, bus_data_i};
        cmd_strobe_o = 1'b0;
        repeat (4) @(negedge clk_sys_i);
        cmd_addr_o = ~cmd_addr_o;
        bus_data_o = ~bus_data_o;
    endtask
    // acknowledge cycle; rd holds the response byte and its enable
    task automatic ack_cycle(output logic [8:0] rd);
        @(negedge clk_sys_i);
        int_ack_o = 1'b1;
        repeat (8) @(negedge clk_sys_i);
        rd = {bus_oe_i, bus_data_i};
        int_ack_o = 1'b0;
        repeat (6) @(negedge clk_sys_i);
    endtask
endmodule

// >>> verif/host_status_interrupt_port_asserts.sv
// Purpose: concurrent checks on the host port outputs
// Assumes: one clock domain, synchronous active high reset
// Notes:   status bits 7 and 5:3 gated by the live core request level
`timescale 1ns/1ps
module host_status_interrupt_port_asserts (
    input wire logic       clk_sys_i,
    input wire logic       sys_rst_i,
    input wire logic [3:0] dev_addr_i,
    input wire logic       int_ack_i,
    input wire logic [7:0] data_o,
    input wire logic       data_oe_o,
    input wire logic       int_req_o,
    input wire logic       core_req_i,
    input wire logic       core_dir_i,
    input wire logic       core_cmd_i,
    input wire logic       core_msg_i,
    input wire logic       selftest_pass_i,
    input wire logic       rd_strobe_o,
    input wire logic [7:0] status_latch_read_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);
    AST_RST_STATUS: assert property ($past(sys_rst_i) |-> status_latch_read_o == 8'h01 && !int_req_o)
        else $error("status after reset wrong");
    AST_SELFT_HOLD: assert property (status_latch_read_o[0] && !selftest_pass_i |=> status_latch_read_o[0])
        else $error("selftest bit cleared without pass");
    AST_GATED: assert property (!core_req_i |-> {status_latch_read_o[7], status_latch_read_o[5:3]} == 4'h0)
        else $error("phase bits shown without request");
    AST_PHASE: assert property (core_req_i |-> status_latch_read_o[3] && status_latch_read_o[7] == core_dir_i
        && status_latch_read_o[5] == core_cmd_i && status_latch_read_o[4] == core_msg_i)
        else $error("phase bits differ from core");
    AST_PAR_INT: assert property ($rose(status_latch_read_o[1]) |-> ##[0:3] int_req_o)
        else $error("no interrupt on parity error");
    AST_INV_INT: assert property ($rose(status_latch_read_o[2]) |-> ##[0:3] int_req_o)
        else $error("no interrupt on invalid request");
    AST_ACK_RESP: assert property (int_req_o && int_ack_i ##1 int_ack_i [*5] |-> data_oe_o && data_o[3:0] == dev_addr_i)
        else $error("no response byte after acknowledge");
    AST_ACK_DROP: assert property ($fell(int_ack_i) |-> ##[1:6] (!int_req_o && !data_oe_o))
        else $error("request or response not withdrawn");
    AST_RESP_BITS: assert property (int_ack_i && data_oe_o |-> data_o[7] == status_latch_read_o[7]
        && data_o[5] == status_latch_read_o[5] && data_o[4] == status_latch_read_o[4])
        else $error("response phase bits wrong");
    AST_ERR_BIT: assert property (int_ack_i && data_oe_o
        |-> data_o[6] == (status_latch_read_o[1] || status_latch_read_o[2]))
        else $error("response error bit wrong");
    AST_RD_PULSE: assert property (rd_strobe_o |-> data_oe_o ##1 !rd_strobe_o)
        else $error("read strobe not one cycle with data driven");
endmodule
bind host_status_interrupt_port host_status_interrupt_port_asserts chk_i (.*);

// >>> verif/tb_top.sv
// Purpose: self-checking bench for the host status and interrupt port
// Assumes: host model drives the bus, bench drives core levels at negedge
// Notes:   device address fixed, core completion input held low
`timescale 1ns/1ps
module tb_top;
    import host_port_pkg::*;
    localparam logic [3:0] DEV_ADDR = 4'hA;
    logic       clk_sys_i, sys_rst_i, core_req_i, core_dir_i, core_cmd_i, core_msg_i, core_int_i;
    logic       selftest_done_i, selftest_pass_i, cmd_strobe_i, cmd_parity_i, int_ack_i;
    logic       data_oe_o, int_req_o, wr_strobe_o, rd_strobe_o, sw_reset_o, select_o, sw_seen, sel_seen;
    logic [7:0] cmd_addr_i, data_i, data_o, core_rd_data_i, wr_data_o, status_latch_read_o, wr_seen;
    logic [8:0] rd;
    logic [2:0] ph [5] = '{3'b010, 3'b001, 3'b101, 3'b110, 3'b111};
    int         num_errors = 0;
    int         n_checks   = 0;
    int         cycles     = 0;
    host_model host (.clk_sys_i(clk_sys_i), .bus_data_i(data_o), .bus_oe_i(data_oe_o), .cmd_addr_o(cmd_addr_i),
        .cmd_strobe_o(cmd_strobe_i), .cmd_parity_o(cmd_parity_i), .int_ack_o(int_ack_i), .bus_data_o(data_i));
    host_status_interrupt_port dut (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .dev_addr_i(DEV_ADDR),
        .cmd_addr_i(cmd_addr_i), .cmd_strobe_i(cmd_strobe_i), .cmd_parity_i(cmd_parity_i), .int_ack_i(int_ack_i),
        .data_i(data_i), .data_o(data_o), .data_oe_o(data_oe_o), .int_req_o(int_req_o), .core_req_i(core_req_i),
        .core_dir_i(core_dir_i), .core_cmd_i(core_cmd_i), .core_msg_i(core_msg_i), .core_int_i(core_int_i),
        .core_done_i(1'b0), .selftest_done_i(selftest_done_i), .selftest_pass_i(selftest_pass_i),
        .core_rd_data_i(core_rd_data_i), .wr_data_o(wr_data_o), .wr_strobe_o(wr_strobe_o),
        .rd_strobe_o(rd_strobe_o), .sw_reset_o(sw_reset_o), .select_o(select_o),
        .status_latch_read_o(status_latch_read_o));
    task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic pulse_int();
        @(negedge clk_sys_i);
        core_int_i = 1'b1;
        @(negedge clk_sys_i);
        core_int_i = 1'b0;
        repeat (3) @(negedge clk_sys_i);
    endtask
    initial begin
        clk_sys_i = 1'b0;
        forever #12.5 clk_sys_i = ~clk_sys_i;
    end
    always @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            wr_seen  <= 8'h00;
            sw_seen  <= 1'b0;
            sel_seen <= 1'b0;
        end else begin
            wr_seen  <= wr_strobe_o ? wr_data_o : wr_seen;
            sw_seen  <= sw_seen | sw_reset_o;
            sel_seen <= sel_seen | select_o;
        end
        cycles   <= cycles + 1;
        if (cycles == 5000) begin
            num_errors++;
            report_and_stop();
        end
    end
    initial begin
        {sys_rst_i, core_req_i, core_dir_i, core_cmd_i, core_msg_i, core_int_i} = 6'h20;
        {selftest_done_i, selftest_pass_i, core_rd_data_i} = 10'h000;
        repeat (16) @(negedge clk_sys_i);
        sys_rst_i = 1'b0;
        chk("status", 9'h001, {1'b0, status_latch_read_o});
        host.command(CMD_STATUS_READ, DEV_ADDR, 1'b0, 8'h00, rd);
        chk("status read", 9'h101, rd);
        host.command(CMD_ID_READ, DEV_ADDR, 1'b0, 8'h00, rd);
        chk("id read", {1'b1, ID_BYTE_VALUE}, rd);
        host.command(CMD_STATUS_READ, 4'h5, 1'b0, 8'h00, rd);
        chk("other address oe", 9'h000, {8'h00, rd[8]});
        selftest_done_i = 1'b1;
        selftest_pass_i = 1'b1;
        repeat (3) @(negedge clk_sys_i);
        chk("status", 9'h000, {1'b0, status_latch_read_o});
        host.command(CMD_READ_DATA, DEV_ADDR, 1'b0, 8'h00, rd);
        chk("status", 9'h004, {1'b0, status_latch_read_o});
        chk("int_req", 9'h001, {8'h00, int_req_o});
        host.ack_cycle(rd);
        chk("response", {1'b1, 4'h4, DEV_ADDR}, rd);
        chk("int_req", 9'h000, {8'h00, int_req_o});
        host.command(CMD_STATUS_READ, 4'h5, 1'b1, 8'h00, rd);
        chk("status", 9'h006, {1'b0, status_latch_read_o});
        host.ack_cycle(rd);
        chk("response", {1'b1, 4'h4, DEV_ADDR}, rd);
        host.command(CMD_SW_RESET, DEV_ADDR, 1'b0, 8'h00, rd);
        chk("reset", 9'h101, {1'b1, 7'h00, sw_seen});
        chk("status", 9'h000, {1'b0, status_latch_read_o});
        host.command(CMD_INT_ENABLE, DEV_ADDR, 1'b0, 8'h00, rd);
        host.command(CMD_SELECT, DEV_ADDR, 1'b0, 8'h00, rd);
        chk("status", 9'h040, {1'b0, status_latch_read_o});
        chk("select", 9'h001, {8'h00, sel_seen});
        foreach (ph[i]) begin
            @(negedge clk_sys_i);
            {core_dir_i, core_cmd_i, core_msg_i} = ph[i];
            core_req_i = 1'b1;
            pulse_int();
            chk("status", {1'b0, ph[i][2], 1'b1, ph[i][1:0], 4'h8}, {1'b0, status_latch_read_o});
            chk("int_req", 9'h001, {8'h00, int_req_o});
            host.ack_cycle(rd);
            chk("response", {1'b1, ph[i][2], 1'b0, ph[i][1:0], DEV_ADDR}, rd);
            chk("int_req", 9'h000, {8'h00, int_req_o});
        end
        {core_dir_i, core_cmd_i, core_msg_i} = 3'b000;
        host.command(CMD_WRITE_DATA, DEV_ADDR, 1'b0, 8'h5C, rd);
        chk("write data", 9'h05C, {1'b0, wr_seen});
        {core_dir_i, core_cmd_i, core_msg_i, core_rd_data_i} = 11'h7C3;
        host.command(CMD_READ_DATA, DEV_ADDR, 1'b0, 8'h00, rd);
        chk("read data", 9'h1C3, rd);
        core_req_i = 1'b0;
        repeat (3) @(negedge clk_sys_i);
        chk("status", 9'h000, {1'b0, status_latch_read_o});
        host.command(CMD_INT_DISABLE, DEV_ADDR, 1'b0, 8'h00, rd);
        pulse_int();
        chk("int_req", 9'h000, {8'h00, int_req_o});
        report_and_stop();
    end
endmodule
